/* design/pscl_loader.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_loader #(
  parameter int REG_COUNT = pscl_pkg::REG_COUNT,
  parameter int CHAN_COUNT = pscl_pkg::CHAN_COUNT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic configSourceSelect,
  input wire logic powerDownPin_b,
  input wire logic [11:0] gpioLevel,
  input wire logic [CHAN_COUNT-1:0] sourceValid,
  input wire logic hostWrEn,
  input wire logic hostRdEn,
  input wire logic [pscl_pkg::IDX_W-1:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic eeWrEn,
  input wire logic [pscl_pkg::SRC_ADDR_W-1:0] eeWrAddr,
  input wire logic [7:0] eeWrData,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  output logic hostIfEnable,
  output logic loadDone,
  output logic hardMode,
  output logic configError,
  output logic [1:0] configSource,
  output logic [5:0] pageSelect,
  output logic [1:0] busAddrLsb,
  output logic outputSync,
  output logic marginEnable,
  output logic [1:0] marginSelect,
  output logic [7:0] uniqueId,
  output logic [8*CHAN_COUNT-1:0] outDivCode,
  output logic [2*CHAN_COUNT-1:0] outFormat,
  output logic [CHAN_COUNT-1:0] chanActive,
  output logic [CHAN_COUNT-1:0] chanForceLow,
  output logic [CHAN_COUNT-1:0] chanTerminate
);

  // ****************************************
  // Pin decoding
  // ****************************************
  function automatic logic [1:0] lvlOf(input logic [11:0] g, input int i);
    return g[2*i +: 2];
  endfunction : lvlOf

  function automatic logic [3:0] triVal(input logic [1:0] l);
    logic [3:0] v;
    v = 4'h1;
    if (l == pscl_pkg::LVL_LOW) begin
      v = 4'h0;
    end else if (l == pscl_pkg::LVL_HIGH) begin
      v = 4'h2;
    end
    return v;
  endfunction : triVal

  function automatic logic pinHigh(input logic [11:0] g, input int i);
    return lvlOf(g, i) == pscl_pkg::LVL_HIGH;
  endfunction : pinHigh

  pscl_pkg::pscl_state_e state_r, state_nxt;
  logic [5:0] strapBits;
  logic [3:0] softCombo;
  logic softDefault;
  logic softBad;
  logic [2:0] softPage;
  logic [1:0] softAddr;
  logic [1:0] pin1Lvl;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_strap
      assign strapBits[gi] = pinHigh(gpioLevel, gi);
    end
  endgenerate

  assign softCombo = 4'((triVal(lvlOf(gpioLevel, 3)) * 4'h3) + triVal(lvlOf(gpioLevel, 2)));
  assign softDefault = softCombo == pscl_pkg::COMBO_DEF;
  assign softBad = softCombo >= pscl_pkg::COMBO_BAD;
  assign softPage = (softCombo > pscl_pkg::COMBO_DEF) ? 3'(softCombo - 4'h1) : softCombo[2:0];
  assign pin1Lvl = lvlOf(gpioLevel, 1);
  assign softAddr = (pin1Lvl == pscl_pkg::LVL_LOW) ? pscl_pkg::ADDR_GND :
                    (pin1Lvl == pscl_pkg::LVL_HIGH) ? pscl_pkg::ADDR_VDD :
                    pscl_pkg::ADDR_MID;

  // ****************************************
  // Memories
  // ****************************************
  pscl_mem_if #(.ADDR_W(pscl_pkg::IDX_W), .DATA_W(8)) regBus();
  pscl_mem_if #(.ADDR_W(pscl_pkg::SRC_ADDR_W), .DATA_W(8)) srcBus();

  pscl_regfile #(.DEPTH(REG_COUNT)) u_regfile (
    .clk(clk),
    .rst_b(rst_b),
    .bus(regBus)
  );

  pscl_page_src u_page_src (
    .clk(clk),
    .rst_b(rst_b),
    .srcKind(configSource),
    .romPage(pageSelect),
    .bus(srcBus)
  );

  // ****************************************
  // Load sequencing
  // ****************************************
  logic [pscl_pkg::IDX_W-1:0] ldIdx_r;
  logic [pscl_pkg::IDX_W-1:0] ldWrIdx_r;
  logic ldIssue_r;
  logic ldWr_r;
  logic ldLast;
  logic hostWrOk;
  logic hostRdOk;
  logic powerDown;
  logic enterRun;

  assign powerDown = !powerDownPin_b;
  assign ldLast = ldWr_r && (ldWrIdx_r == pscl_pkg::LAST_IDX);
  assign enterRun = (state_r == pscl_pkg::ST_LOAD) && ldLast;
  assign hostWrOk = hostWrEn && hostIfEnable && (32'(hostAddr) < REG_COUNT);
  assign hostRdOk = hostRdEn && hostIfEnable && (32'(hostAddr) < REG_COUNT);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pscl_pkg::ST_RESET: begin
        if (!powerDown) begin
          state_nxt = pscl_pkg::ST_LATCH;
        end
      end
      pscl_pkg::ST_LATCH: begin
        state_nxt = pscl_pkg::ST_LOAD;
      end
      pscl_pkg::ST_LOAD: begin
        if (ldLast) begin
          state_nxt = pscl_pkg::ST_RUN;
        end
      end
      pscl_pkg::ST_RUN: begin
        state_nxt = pscl_pkg::ST_RUN;
      end
    endcase
    if (powerDown) begin
      state_nxt = pscl_pkg::ST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= pscl_pkg::ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Straps captured once per reset or power-down release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hardMode <= 1'b0;
      configSource <= pscl_pkg::SRC_DEF;
      pageSelect <= 6'h00;
      configError <= 1'b0;
      busAddrLsb <= pscl_pkg::ADDR_HARD;
      marginEnable <= 1'b0;
      marginSelect <= pscl_pkg::LVL_LOW;
    end else if (state_r == pscl_pkg::ST_LATCH) begin
      hardMode <= configSourceSelect;
      configError <= !configSourceSelect && softBad;
      if (configSourceSelect) begin
        configSource <= pscl_pkg::SRC_ROM;
        pageSelect <= strapBits;
        busAddrLsb <= pscl_pkg::ADDR_HARD;
        marginEnable <= 1'b0;
        marginSelect <= pscl_pkg::LVL_LOW;
      end else begin
        configSource <= (softDefault || softBad) ? pscl_pkg::SRC_DEF : pscl_pkg::SRC_EE;
        pageSelect <= {3'h0, softPage};
        busAddrLsb <= softAddr;
        marginEnable <= strapBits[4];
        marginSelect <= lvlOf(gpioLevel, 5);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || state_r != pscl_pkg::ST_LOAD) begin
      ldIdx_r <= '0;
      ldIssue_r <= (state_r == pscl_pkg::ST_LATCH);
      ldWr_r <= 1'b0;
      ldWrIdx_r <= '0;
    end else begin
      ldWr_r <= ldIssue_r;
      ldWrIdx_r <= ldIdx_r;
      if (ldIssue_r) begin
        ldIssue_r <= ldIdx_r != pscl_pkg::LAST_IDX;
        ldIdx_r <= ldIdx_r + 7'h01;
      end
    end
  end

  assign srcBus.rdAddr = {pageSelect[2:0], ldIdx_r};
  assign srcBus.wrEn = eeWrEn;
  assign srcBus.wrAddr = eeWrAddr;
  assign srcBus.wrData = eeWrData;

  // Page bytes hold format, mux, status role, input and PLL settings
  assign regBus.wrEn = ldWr_r || hostWrOk;
  assign regBus.wrAddr = ldWr_r ? ldWrIdx_r : hostAddr;
  assign regBus.wrData = ldWr_r ? srcBus.rdData : hostWrData;
  assign regBus.rdAddr = hostAddr;
  assign hostRdData = regBus.rdData;

  // ****************************************
  // Host side and run status
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hostIfEnable <= 1'b0;
      loadDone <= 1'b0;
      hostRdValid <= 1'b0;
      outputSync <= 1'b0;
    end else begin
      hostIfEnable <= (state_nxt == pscl_pkg::ST_RUN);
      loadDone <= (state_nxt == pscl_pkg::ST_RUN);
      hostRdValid <= hostRdOk;
      if (hardMode) begin
        outputSync <= enterRun;
      end else begin
        outputSync <= (state_r == pscl_pkg::ST_RUN) && !strapBits[0];
      end
    end
  end

  // ****************************************
  // Shadow copies of live controls
  // ****************************************
  logic [7:0] muteByp_r;
  logic [7:0] muteLvl_r;

  function automatic logic hits(input logic [pscl_pkg::IDX_W-1:0] a,
                                input logic [pscl_pkg::IDX_W-1:0] idx);
    return a == idx;
  endfunction : hits

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      muteByp_r <= pscl_pkg::MUTE_BYP_RST;
      muteLvl_r <= pscl_pkg::MUTE_LVL_RST;
      uniqueId <= pscl_pkg::UID_RST;
    end else if (regBus.wrEn) begin
      if (hits(regBus.wrAddr, pscl_pkg::MUTE_BYP_IDX)) begin
        muteByp_r <= regBus.wrData;
      end
      if (hits(regBus.wrAddr, pscl_pkg::MUTE_LVL_IDX)) begin
        muteLvl_r <= regBus.wrData;
      end
      if (hits(regBus.wrAddr, pscl_pkg::UID_IDX)) begin
        uniqueId <= regBus.wrData;
      end
    end
  end

  // ****************************************
  // Per-channel divider, format and mute
  // ****************************************
  logic running;
  assign running = state_nxt == pscl_pkg::ST_RUN;

  generate
    for (gi = 0; gi < CHAN_COUNT; gi++) begin : g_chan
      localparam logic [pscl_pkg::IDX_W-1:0] DIV_IDX = pscl_pkg::DIV_BASE_IDX + 7'(gi);
      localparam logic [pscl_pkg::IDX_W-1:0] FMT_IDX =
        (gi < 4) ? pscl_pkg::FMT_LO_IDX : pscl_pkg::FMT_HI_IDX;
      localparam int FMT_POS = 2 * (gi % 4);
      logic [1:0] fmt;
      logic muted;
      logic lowWhenMuted;

      assign fmt = outFormat[2*gi +: 2];
      assign muted = !sourceValid[gi] && !muteByp_r[gi];
      assign lowWhenMuted = (fmt != pscl_pkg::FMT_ACDIFF) || !muteLvl_r[gi];

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          outDivCode[8*gi +: 8] <= pscl_pkg::DIV_RST;
          outFormat[2*gi +: 2] <= pscl_pkg::FMT_RST[1:0];
        end else if (regBus.wrEn) begin
          if (hits(regBus.wrAddr, DIV_IDX)) begin
            outDivCode[8*gi +: 8] <= regBus.wrData;
          end
          if (hits(regBus.wrAddr, FMT_IDX)) begin
            outFormat[2*gi +: 2] <= regBus.wrData[FMT_POS +: 2];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_b || !running || fmt == pscl_pkg::FMT_OFF) begin
          chanActive[gi] <= 1'b0;
          chanForceLow[gi] <= 1'b0;
          chanTerminate[gi] <= 1'b0;
        end else begin
          chanActive[gi] <= !muted;
          chanForceLow[gi] <= muted && lowWhenMuted;
          chanTerminate[gi] <= muted && !lowWhenMuted;
        end
      end
    end
  endgenerate

endmodule : pscl_loader
`default_nettype wire

/* design/pscl_pkg.sv */
package pscl_pkg;

  // ****************************************
  // Register file geometry
  // ****************************************
  localparam int REG_COUNT = 124;
  localparam int IDX_W = 7;
  localparam int DATA_W = 8;
  localparam int CHAN_COUNT = 8;
  localparam int ROM_PAGES = 64;
  localparam int EE_PAGES = 6;
  localparam int EE_PAGE_W = 3;
  localparam int SRC_ADDR_W = EE_PAGE_W + IDX_W;
  localparam logic [IDX_W-1:0] LAST_IDX = 7'h7B;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [IDX_W-1:0] UID_IDX = 7'h02;
  localparam logic [IDX_W-1:0] FMT_LO_IDX = 7'h10;
  localparam logic [IDX_W-1:0] FMT_HI_IDX = 7'h11;
  localparam logic [IDX_W-1:0] MUTE_BYP_IDX = 7'h14;
  localparam logic [IDX_W-1:0] MUTE_LVL_IDX = 7'h15;
  localparam logic [IDX_W-1:0] DIV_BASE_IDX = 7'h18;

  // ****************************************
  // Reset and default values
  // ****************************************
  localparam logic [7:0] MUTE_BYP_RST = 8'h00;
  localparam logic [7:0] MUTE_LVL_RST = 8'hFF;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] UID_RST = 8'h00;
  localparam logic [7:0] FILL_RST = 8'h00;

  // ****************************************
  // Pin levels and encodings
  // ****************************************
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_FLOAT = 2'h3;
  localparam logic [1:0] ADDR_HARD = 2'h0;
  localparam logic [1:0] ADDR_GND = 2'h0;
  localparam logic [1:0] ADDR_MID = 2'h1;
  localparam logic [1:0] ADDR_VDD = 2'h3;
  localparam logic [1:0] FMT_OFF = 2'h0;
  localparam logic [1:0] FMT_ACDIFF = 2'h1;
  localparam logic [1:0] FMT_HCSL = 2'h2;
  localparam logic [1:0] FMT_CMOS = 2'h3;
  localparam logic [1:0] SRC_ROM = 2'h0;
  localparam logic [1:0] SRC_EE = 2'h1;
  localparam logic [1:0] SRC_DEF = 2'h2;
  localparam logic [3:0] COMBO_DEF = 4'h4;
  localparam logic [3:0] COMBO_BAD = 4'h7;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LATCH = 2'b01,
    ST_LOAD = 2'b11,
    ST_RUN = 2'b10
  } pscl_state_e;

  // Hardware default contents
  function automatic logic [7:0] defaultByte(input logic [IDX_W-1:0] idx);
    logic [7:0] b;
    b = FILL_RST;
    if (idx == MUTE_LVL_IDX) begin
      b = MUTE_LVL_RST;
    end
    return b;
  endfunction : defaultByte

  // Fixed page contents; pattern is arbitrary
  function automatic logic [7:0] romByte(input logic [5:0] page, input logic [IDX_W-1:0] idx);
    logic [7:0] b;
    b = {page, 2'h0} ^ {1'b0, idx};
    if (idx == MUTE_BYP_IDX) begin
      b = MUTE_BYP_RST;
    end
    if (idx == MUTE_LVL_IDX) begin
      b = MUTE_LVL_RST;
    end
    return b;
  endfunction : romByte

endpackage : pscl_pkg

/* design/pscl_mem_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pscl_mem_if #(parameter int ADDR_W = 7, parameter int DATA_W = 8);
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;
  modport master(output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem(input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : pscl_mem_if
`default_nettype wire

/* design/pscl_regfile.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_regfile #(
  parameter int DEPTH = 124
) (
  input wire logic clk,
  input wire logic rst_b,
  pscl_mem_if.mem bus
);
  logic [7:0] mem [DEPTH];

  // ****************************************
  // Write and registered read
  // ****************************************
  always_ff @(posedge clk) begin
    if (bus.wrEn) begin
      mem[bus.wrAddr] <= bus.wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus.rdData <= 8'h00;
    end else begin
      bus.rdData <= mem[bus.rdAddr];
    end
  end
endmodule : pscl_regfile
`default_nettype wire

/* design/pscl_page_src.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_page_src #(
  parameter int EE_DEPTH = 768
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] srcKind,
  input wire logic [5:0] romPage,
  pscl_mem_if.mem bus
);
  logic [7:0] eeMem [EE_DEPTH];
  logic [pscl_pkg::IDX_W-1:0] rdIdx;
  logic [7:0] romData;
  logic [7:0] defData;

  assign rdIdx = bus.rdAddr[pscl_pkg::IDX_W-1:0];
  assign romData = pscl_pkg::romByte(romPage, rdIdx);
  assign defData = pscl_pkg::defaultByte(rdIdx);

  // ****************************************
  // Nonvolatile page store
  // ****************************************
  always_ff @(posedge clk) begin
    if (bus.wrEn) begin
      eeMem[bus.wrAddr] <= bus.wrData;
    end
  end

  // ****************************************
  // Registered page byte
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus.rdData <= 8'h00;
    end else if (srcKind == pscl_pkg::SRC_ROM) begin
      bus.rdData <= romData;
    end else if (srcKind == pscl_pkg::SRC_EE) begin
      bus.rdData <= eeMem[bus.rdAddr];
    end else begin
      bus.rdData <= defData;
    end
  end
endmodule : pscl_page_src
`default_nettype wire

/* tb/pscl_loader_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_loader_sva #(
  parameter int REG_COUNT = 124,
  parameter int CHAN_COUNT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hostWrEn,
  input wire logic hostRdEn,
  input wire logic [pscl_pkg::IDX_W-1:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostRdValid,
  input wire logic hostIfEnable,
  input wire logic hardMode,
  input wire logic [1:0] busAddrLsb,
  input wire logic outputSync,
  input wire logic [7:0] uniqueId,
  input wire logic [8*CHAN_COUNT-1:0] outDivCode,
  input wire logic [2*CHAN_COUNT-1:0] outFormat,
  input wire logic [CHAN_COUNT-1:0] chanActive,
  input wire logic [CHAN_COUNT-1:0] chanForceLow,
  input wire logic [CHAN_COUNT-1:0] chanTerminate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic hostOk;
  assign hostOk = hostIfEnable && (32'(hostAddr) < REG_COUNT);
  // ****************************************
  // Sequences
  // ****************************************
  sequence sLoadEnd;
    $rose(hostIfEnable);
  endsequence
  sequence sWrite(idx);
    hostWrEn && hostOk && (hostAddr == idx);
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_outputs_held: assert property (!hostIfEnable |-> ((chanActive | chanForceLow | chanTerminate) == '0))
    else $error("channel driven before load done");
  a_hard_addr: assert property (hostIfEnable && hardMode |-> busAddrLsb == pscl_pkg::ADDR_HARD)
    else $error("hard mode address bits not zero");
  a_hard_sync: assert property (sLoadEnd ##0 hardMode |-> outputSync ##1 !outputSync)
    else $error("no single sync pulse after hard load");
  a_read_answer: assert property (hostRdEn && hostOk |=> hostRdValid)
    else $error("read not answered");
  a_read_refused: assert property (!(hostRdEn && hostOk) |=> !hostRdValid)
    else $error("read valid without request");
  a_div_write: assert property (sWrite(pscl_pkg::DIV_BASE_IDX) |=> outDivCode[7:0] == $past(hostWrData))
    else $error("divider shadow not updated");
  a_uid_write: assert property (sWrite(pscl_pkg::UID_IDX) |=> uniqueId == $past(hostWrData))
    else $error("identifier shadow not updated");
  a_drive_excl: assert property (((chanActive & chanForceLow) | (chanActive & chanTerminate)
    | (chanForceLow & chanTerminate)) == '0)
    else $error("channel in two drive states");
  a_term_acdiff: assert property (chanTerminate[0] |-> $past(outFormat[1:0]) == pscl_pkg::FMT_ACDIFF)
    else $error("termination on non ac format");
endmodule : pscl_loader_sva
`default_nettype wire

/* tb/pscl_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_host_model (
  input wire logic clk,
  input wire logic hostIfEnable,
  output logic configSourceSelect,
  output logic powerDownPin_b,
  output logic [11:0] gpioLevel,
  output logic hostWrEn,
  output logic hostRdEn,
  output logic [6:0] hostAddr,
  output logic [7:0] hostWrData
);
  initial begin
    configSourceSelect = 1'h1;
    powerDownPin_b = 1'h1;
    gpioLevel = 12'h000;
    hostWrEn = 1'h0;
    hostRdEn = 1'h0;
    hostAddr = 7'h00;
    hostWrData = 8'h00;
  end
  // ****************************************
  // One-cycle access once host side is on
  // ****************************************
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
    while (hostIfEnable !== 1'h1) @(posedge clk);
    @(posedge clk);
    hostWrEn <= wr;
    hostRdEn <= !wr;
    hostAddr <= a;
    hostWrData <= d;
    @(posedge clk);
    hostWrEn <= 1'h0;
    hostRdEn <= 1'h0;
    hostAddr <= ~a;
    hostWrData <= ~d;
  endtask : access
  // ****************************************
  // Mode strap first, then power-down pulse
  // ****************************************
  task automatic powerCycle(input logic mode, input logic [11:0] straps);
    @(posedge clk);
    configSourceSelect <= mode;
    gpioLevel <= straps;
    @(posedge clk);
    powerDownPin_b <= 1'h0;
    repeat (2) @(posedge clk);
    powerDownPin_b <= 1'h1;
  endtask : powerCycle
endmodule : pscl_host_model
`default_nettype wire

/* tb/pscl_loader_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pscl_loader_tb;
  logic clk, rst_b, cfgSel, pdn_b, hostWrEn, hostRdEn, eeWrEn;
  logic [11:0] gpio;
  logic [7:0] srcValid, hostWrData, eeWrData, hostRdData, uniqueId;
  logic [6:0] hostAddr;
  logic [9:0] eeWrAddr;
  logic hostRdValid, hostIfEnable, loadDone, hardMode, configError, outputSync, marginEnable;
  logic [1:0] configSource, busAddrLsb, marginSelect;
  logic [5:0] pageSelect;
  logic [63:0] outDivCode;
  logic [15:0] outFormat;
  logic [7:0] chanActive, chanForceLow, chanTerminate;
  int num_errors = 0;
  int compares = 0;
  logic [31:0] seed = 32'h12;
  logic [7:0] expQ[$];
  logic [7:0] muteTab[7] = '{8'hE2, 8'h61, 8'h42, 8'hA2, 8'h74, 8'hEC, 8'h20};

  pscl_loader dut_u (.clk(clk), .rst_b(rst_b), .configSourceSelect(cfgSel),
    .powerDownPin_b(pdn_b), .gpioLevel(gpio), .sourceValid(srcValid), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostAddr(hostAddr), .hostWrData(hostWrData), .eeWrEn(eeWrEn),
    .eeWrAddr(eeWrAddr), .eeWrData(eeWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .hostIfEnable(hostIfEnable), .loadDone(loadDone),
    .hardMode(hardMode), .configError(configError), .configSource(configSource),
    .pageSelect(pageSelect), .busAddrLsb(busAddrLsb), .outputSync(outputSync),
    .marginEnable(marginEnable), .marginSelect(marginSelect), .uniqueId(uniqueId),
    .outDivCode(outDivCode), .outFormat(outFormat), .chanActive(chanActive),
    .chanForceLow(chanForceLow), .chanTerminate(chanTerminate));
  pscl_host_model hostM (.clk(clk), .hostIfEnable(hostIfEnable), .configSourceSelect(cfgSel),
    .powerDownPin_b(pdn_b), .gpioLevel(gpio), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
    .hostAddr(hostAddr), .hostWrData(hostWrData));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] romExp(input logic [5:0] pg, input logic [6:0] ix);
    if (ix == pscl_pkg::MUTE_BYP_IDX) return 8'h00;
    if (ix == pscl_pkg::MUTE_LVL_IDX) return 8'hFF;
    return {pg, 2'h0} ^ {1'h0, ix};
  endfunction : romExp
  function automatic logic [7:0] eeExp(input logic [2:0] p, input logic [6:0] ix);
    return {p, 5'h00} ^ {1'h0, ix};
  endfunction : eeExp
  function automatic logic [1:0] lv(input int t, input bit flt);
    if (t == 1) return flt ? pscl_pkg::LVL_FLOAT : pscl_pkg::LVL_MID;
    return (t == 2) ? pscl_pkg::LVL_HIGH : pscl_pkg::LVL_LOW;
  endfunction : lv
  task automatic check(input string what, input logic [7:0] expv, input logic [7:0] seen);
    compares++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expQ.push_back(e);
    hostM.access(1'h0, a, 8'h00);
  endtask : rd
  task automatic waitLoad();
    int n;
    n = 0;
    while (hostIfEnable !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("host enable", 8'h01, 8'(hostIfEnable));
    check("load done", 8'h01, 8'(loadDone));
  endtask : waitLoad
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // ****************************************
  // Read monitor and watchdog
  // ****************************************
  always @(negedge clk) begin
    if (hostRdValid === 1'h1) begin
      if (expQ.size() == 0) check("read valid", 8'h00, 8'h01);
      else check("read data", expQ.pop_front(), hostRdData);
    end
  end
  initial begin
    #2000000;
    num_errors++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] row, v;
    logic [5:0] pg;
    logic [6:0] ix;
    logic [11:0] g;
    logic def;
    int p, t2;
    rst_b = 1'h0;
    srcValid = 8'hFF;
    eeWrEn = 1'h0;
    eeWrAddr = 10'h000;
    eeWrData = 8'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      pg = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'(xs());
      for (int b = 0; b < 6; b++) g[2*b +: 2] = pg[b] ? pscl_pkg::LVL_HIGH : pscl_pkg::LVL_LOW;
      if (i > 0) hostM.powerCycle(1'h1, g);
      waitLoad();
      check("hard mode", 8'h01, 8'(hardMode));
      check("source", 8'(pscl_pkg::SRC_ROM), 8'(configSource));
      check("page", 8'(pg), 8'(pageSelect));
      check("addr lsb", 8'(pscl_pkg::ADDR_HARD), 8'(busAddrLsb));
      ix = 7'(xs() % 124);
      rd(ix, romExp(pg, ix));
      rd(pscl_pkg::LAST_IDX, romExp(pg, pscl_pkg::LAST_IDX));
    end
    hostM.access(1'h0, 7'h7C, 8'h00);
    hostM.access(1'h1, 7'h7C, 8'h11);
    rd(pscl_pkg::MUTE_LVL_IDX, 8'hFF);
    $display("test hard pages done");
    for (int k = 0; k < 7; k++) begin
      row = muteTab[k];
      hostM.access(1'h1, pscl_pkg::FMT_LO_IDX, {6'h00, row[7:6]});
      hostM.access(1'h1, pscl_pkg::MUTE_LVL_IDX, {7'h00, row[5]});
      hostM.access(1'h1, pscl_pkg::MUTE_BYP_IDX, {7'h00, row[4]});
      srcValid <= {7'h7F, row[3]};
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("drive", {5'h00, row[2:0]}, {5'h00, chanActive[0], chanForceLow[0], chanTerminate[0]});
      check("format", 8'(row[7:6]), 8'(outFormat[1:0]));
    end
    srcValid <= 8'hFF;
    for (int ch = 0; ch < 8; ch += 7) begin
      v = (ch == 7) ? 8'hFF : 8'(xs());
      hostM.access(1'h1, pscl_pkg::DIV_BASE_IDX + 7'(ch), v);
      rd(pscl_pkg::DIV_BASE_IDX + 7'(ch), v);
      @(negedge clk);
      check("divider", v, outDivCode[8*ch +: 8]);
    end
    hostM.access(1'h1, pscl_pkg::UID_IDX, 8'h5A);
    @(negedge clk);
    check("uid", 8'h5A, uniqueId);
    $display("test host writes done");
    for (int q = 0; q < 744; q++) begin
      @(posedge clk);
      eeWrEn <= 1'h1;
      eeWrAddr <= {3'(q / 124), 7'(q % 124)};
      eeWrData <= eeExp(3'(q / 124), 7'(q % 124));
    end
    @(posedge clk);
    eeWrEn <= 1'h0;
    for (int c = 0; c < 9; c++) begin
      t2 = c % 3;
      g = {2'(xs()), (c % 2) ? 2'h2 : 2'h0, lv(c / 3, c == 4), lv(t2, c == 4), lv(t2, 0),
        (c % 2) ? 2'h0 : 2'h2};
      def = (c == 4) || (c >= 7);
      p = (c < 4) ? c : c - 1;
      hostM.powerCycle(1'h0, g);
      waitLoad();
      check("hard mode", 8'h00, 8'(hardMode));
      check("source", 8'(def ? pscl_pkg::SRC_DEF : pscl_pkg::SRC_EE), 8'(configSource));
      check("error", 8'(c >= 7), 8'(configError));
      if (!def) check("page", 8'(p), 8'(pageSelect));
      check("uid", def ? pscl_pkg::UID_RST : eeExp(3'(p), pscl_pkg::UID_IDX), uniqueId);
      check("addr lsb", (t2 == 2) ? 8'h03 : 8'(t2), 8'(busAddrLsb));
      @(negedge clk);
      check("sync", 8'(c % 2), 8'(outputSync));
      check("margin on", 8'(c % 2), 8'(marginEnable));
      check("margin sel", 8'(g[11:10]), 8'(marginSelect));
      rd(pscl_pkg::MUTE_LVL_IDX, def ? 8'hFF : eeExp(3'(p), pscl_pkg::MUTE_LVL_IDX));
    end
    $display("test soft combos done");
    repeat (3) @(negedge clk);
    check("pending reads", 8'h00, 8'(expQ.size()));
    finish_test();
  end
endmodule : pscl_loader_tb

bind pscl_loader pscl_loader_sva #(.REG_COUNT(REG_COUNT), .CHAN_COUNT(CHAN_COUNT)) svaU (
  .clk(clk), .rst_b(rst_b), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostAddr(hostAddr),
  .hostWrData(hostWrData), .hostRdValid(hostRdValid), .hostIfEnable(hostIfEnable),
  .hardMode(hardMode), .busAddrLsb(busAddrLsb), .outputSync(outputSync), .uniqueId(uniqueId),
  .outDivCode(outDivCode), .outFormat(outFormat), .chanActive(chanActive),
  .chanForceLow(chanForceLow), .chanTerminate(chanTerminate));
`default_nettype wire
